// ===== bus_side_gpio_ports.sv
`timescale 1ns/1ps

// Functional notes
// - Port CD data: 8 bits, read gives pin levels, write sets outputs, byte access
// - Port CD direction per pin; CD pins are always plain I/O
// - Port CM has six pins with own data and direction bits
// - CM control mode: pin0 wait, pin1 clock out, pin2 hold ack, pin3 hold request
// - Port CM data: 8 bits, read gives pin levels, write sets outputs
// - CM, CS, CT direction registers: 8 bits, per pin, byte access
// - CM, CS, CT function select registers: 8 bits, per pin, byte access
// - Port CS eight pins; control mode pins 0..3 drive chip selects 0..3
// - Port CS data: 8 bits, read gives pin levels, write sets outputs
// - Port CT control mode: pins 0,1 write strobes, pin 4 read, pin 6 address strobe
// - Port CT data: 8 bits, read gives pin levels, write sets outputs
// - Port DL sixteen pins; control mode pin n carries address/data bit n
// - DL data whole only in 16-bit units; byte views accept byte access
// - DL bits 8..15 byte access goes through bits 0..7 of the upper view
// - DL direction 16 bits whole; lower and upper byte views accept byte access
// - DL function select bit 0 selects plain I/O, 1 selects address/data
module bus_side_gpio_ports (
  input  wire logic                              ref_clk,
  input  wire logic                              reset_n,
  input  wire logic [gpio_pkg::ADDR_W-1:0]       avs_address,
  input  wire logic                              avs_read,
  input  wire logic                              avs_write,
  input  wire logic [gpio_pkg::BE_W-1:0]         avs_byteenable,
  input  wire logic [gpio_pkg::DATA_W-1:0]       avs_writedata,
  output logic      [gpio_pkg::DATA_W-1:0]       avs_readdata,
  output logic                                   avs_waitrequest,
  input  wire logic [gpio_pkg::CD_PINS-1:0]      cd_pad_in,
  output logic      [gpio_pkg::CD_PINS-1:0]      cd_pad_out,
  output logic      [gpio_pkg::CD_PINS-1:0]      cd_pad_oe_n,
  input  wire logic [gpio_pkg::CM_PINS-1:0]      cm_pad_in,
  output logic      [gpio_pkg::CM_PINS-1:0]      cm_pad_out,
  output logic      [gpio_pkg::CM_PINS-1:0]      cm_pad_oe_n,
  input  wire logic [gpio_pkg::CS_PINS-1:0]      cs_pad_in,
  output logic      [gpio_pkg::CS_PINS-1:0]      cs_pad_out,
  output logic      [gpio_pkg::CS_PINS-1:0]      cs_pad_oe_n,
  input  wire logic [gpio_pkg::CT_PINS-1:0]      ct_pad_in,
  output logic      [gpio_pkg::CT_PINS-1:0]      ct_pad_out,
  output logic      [gpio_pkg::CT_PINS-1:0]      ct_pad_oe_n,
  input  wire logic [gpio_pkg::DL_PINS-1:0]      dl_pad_in,
  output logic      [gpio_pkg::DL_PINS-1:0]      dl_pad_out,
  output logic      [gpio_pkg::DL_PINS-1:0]      dl_pad_oe_n,
  input  wire gpio_pkg::bus_ctrl_out_type        bus_ctrl_out,
  output gpio_pkg::bus_ctrl_in_type              bus_ctrl_in
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] merge8(input logic [7:0] old_v,
                                        input logic [7:0] new_v,
                                        input logic       lane_en);
    merge8 = lane_en ? new_v : old_v;
  endfunction : merge8
  // Per bit: control mode takes the controller value, else the port value
  function automatic logic [15:0] pick(input logic [15:0] mode,
                                       input logic [15:0] ctrl_v,
                                       input logic [15:0] port_v);
    pick = (mode & ctrl_v) | (~mode & port_v);
  endfunction : pick
  // ****************************************
  // Reset release and pin synchronisers
  // ****************************************
  logic                          rst_meta_q;
  logic                          rst_n;
  logic [gpio_pkg::ALL_PINS-1:0] pad_meta_q;
  logic [gpio_pkg::ALL_PINS-1:0] pad_sync_q;
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pad_meta_q <= '0;
      pad_sync_q <= '0;
    end
    else
    begin
      pad_meta_q <= {dl_pad_in, ct_pad_in, cs_pad_in, cm_pad_in, cd_pad_in};
      pad_sync_q <= pad_meta_q;
    end
  end
  logic [3:0]  cd_pin;
  logic [5:0]  cm_pin;
  logic [7:0]  cs_pin;
  logic [7:0]  ct_pin;
  logic [15:0] dl_pin;
  assign cd_pin = pad_sync_q[3:0];
  assign cm_pin = pad_sync_q[9:4];
  assign cs_pin = pad_sync_q[17:10];
  assign ct_pin = pad_sync_q[25:18];
  assign dl_pin = pad_sync_q[41:26];
  // ****************************************
  // Avalon slave: one wait cycle, then answer
  // ****************************************
  gpio_pkg::slave_state_type state_q;
  logic [7:0]                reg_addr;
  logic                      wr_go;
  logic [7:0]                wb0;
  logic [7:0]                wb1;
  logic                      be0;
  logic                      be_half;
  logic [31:0]               rd_mux;
  logic [7:0]  cd_data_q;
  logic [7:0]  cd_dir_q;
  logic [7:0]  cm_data_q;
  logic [7:0]  cm_dir_q;
  logic [7:0]  cm_fsel_q;
  logic [7:0]  cs_data_q;
  logic [7:0]  cs_dir_q;
  logic [7:0]  cs_fsel_q;
  logic [7:0]  ct_data_q;
  logic [7:0]  ct_dir_q;
  logic [7:0]  ct_fsel_q;
  logic [15:0] dl_data_q;
  logic [15:0] dl_dir_q;
  logic [15:0] dl_fsel_q;
  assign reg_addr = {avs_address[7:2], 2'b00};
  // Writes land only at the edge where the master sees waitrequest low
  assign wr_go    = avs_write && !avs_waitrequest;
  assign wb0      = avs_writedata[7:0];
  assign wb1      = avs_writedata[15:8];
  assign be0      = avs_byteenable[0];
  assign be_half  = (avs_byteenable[1:0] == 2'b11);
  always_comb
  begin
    rd_mux = '0;
    if (reg_addr == gpio_pkg::OFF_CD_DATA)
      rd_mux[3:0] = cd_pin;
    else if (reg_addr == gpio_pkg::OFF_CD_DIR)
      rd_mux[7:0] = cd_dir_q;
    else if (reg_addr == gpio_pkg::OFF_CM_DATA)
      rd_mux[5:0] = cm_pin;
    else if (reg_addr == gpio_pkg::OFF_CM_DIR)
      rd_mux[7:0] = cm_dir_q;
    else if (reg_addr == gpio_pkg::OFF_CM_FSEL)
      rd_mux[7:0] = cm_fsel_q;
    else if (reg_addr == gpio_pkg::OFF_CS_DATA)
      rd_mux[7:0] = cs_pin;
    else if (reg_addr == gpio_pkg::OFF_CS_DIR)
      rd_mux[7:0] = cs_dir_q;
    else if (reg_addr == gpio_pkg::OFF_CS_FSEL)
      rd_mux[7:0] = cs_fsel_q;
    else if (reg_addr == gpio_pkg::OFF_CT_DATA)
      rd_mux[7:0] = ct_pin;
    else if (reg_addr == gpio_pkg::OFF_CT_DIR)
      rd_mux[7:0] = ct_dir_q;
    else if (reg_addr == gpio_pkg::OFF_CT_FSEL)
      rd_mux[7:0] = ct_fsel_q;
    else if (reg_addr == gpio_pkg::OFF_DL_DATA)
      rd_mux[15:0] = dl_pin;
    else if (reg_addr == gpio_pkg::OFF_DL_DATA_LO)
      rd_mux[7:0] = dl_pin[7:0];
    else if (reg_addr == gpio_pkg::OFF_DL_DATA_HI)
      rd_mux[7:0] = dl_pin[15:8];
    else if (reg_addr == gpio_pkg::OFF_DL_DIR)
      rd_mux[15:0] = dl_dir_q;
    else if (reg_addr == gpio_pkg::OFF_DL_DIR_LO)
      rd_mux[7:0] = dl_dir_q[7:0];
    else if (reg_addr == gpio_pkg::OFF_DL_DIR_HI)
      rd_mux[7:0] = dl_dir_q[15:8];
    else if (reg_addr == gpio_pkg::OFF_DL_FSEL)
      rd_mux[15:0] = dl_fsel_q;
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q         <= gpio_pkg::SLV_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
    end
    else
    begin
      case (state_q)
        gpio_pkg::SLV_IDLE:
        begin
          if (avs_read || avs_write)
          begin
            state_q         <= gpio_pkg::SLV_DONE;
            avs_waitrequest <= 1'b0;
            avs_readdata    <= avs_read ? rd_mux : '0;
          end
        end
        default:
        begin
          state_q         <= gpio_pkg::SLV_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end
  // ****************************************
  // Port CD registers
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cd_data_q <= gpio_pkg::DATA8_RESET;
      cd_dir_q  <= gpio_pkg::DIR8_RESET;
    end
    else if (wr_go)
    begin
      if (reg_addr == gpio_pkg::OFF_CD_DATA)
        cd_data_q <= merge8(cd_data_q, wb0, be0);
      else if (reg_addr == gpio_pkg::OFF_CD_DIR)
        cd_dir_q <= merge8(cd_dir_q, wb0, be0);
    end
  end
  // ****************************************
  // Ports CM, CS, CT registers
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {cm_data_q, cs_data_q, ct_data_q} <= {3{gpio_pkg::DATA8_RESET}};
      {cm_dir_q, cs_dir_q, ct_dir_q}    <= {3{gpio_pkg::DIR8_RESET}};
      {cm_fsel_q, cs_fsel_q, ct_fsel_q} <= {3{gpio_pkg::FSEL8_RESET}};
    end
    else if (wr_go)
    begin
      if (reg_addr == gpio_pkg::OFF_CM_DATA)
        cm_data_q <= merge8(cm_data_q, wb0, be0);
      else if (reg_addr == gpio_pkg::OFF_CM_DIR)
        cm_dir_q <= merge8(cm_dir_q, wb0, be0);
      else if (reg_addr == gpio_pkg::OFF_CM_FSEL)
        cm_fsel_q <= merge8(cm_fsel_q, wb0, be0);
      else if (reg_addr == gpio_pkg::OFF_CS_DATA)
        cs_data_q <= merge8(cs_data_q, wb0, be0);
      else if (reg_addr == gpio_pkg::OFF_CS_DIR)
        cs_dir_q <= merge8(cs_dir_q, wb0, be0);
      else if (reg_addr == gpio_pkg::OFF_CS_FSEL)
        cs_fsel_q <= merge8(cs_fsel_q, wb0, be0);
      else if (reg_addr == gpio_pkg::OFF_CT_DATA)
        ct_data_q <= merge8(ct_data_q, wb0, be0);
      else if (reg_addr == gpio_pkg::OFF_CT_DIR)
        ct_dir_q <= merge8(ct_dir_q, wb0, be0);
      else if (reg_addr == gpio_pkg::OFF_CT_FSEL)
        ct_fsel_q <= merge8(ct_fsel_q, wb0, be0);
    end
  end
  // ****************************************
  // Port DL registers
  // ****************************************
  // Whole-word views demand both low lanes; a partial write is dropped
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dl_data_q <= gpio_pkg::DATA16_RESET;
      dl_dir_q  <= gpio_pkg::DIR16_RESET;
      dl_fsel_q <= gpio_pkg::FSEL16_RESET;
    end
    else if (wr_go)
    begin
      if (reg_addr == gpio_pkg::OFF_DL_DATA && be_half)
        dl_data_q <= avs_writedata[15:0];
      else if (reg_addr == gpio_pkg::OFF_DL_DATA_LO)
        dl_data_q[7:0] <= merge8(dl_data_q[7:0], wb0, be0);
      else if (reg_addr == gpio_pkg::OFF_DL_DATA_HI)
        dl_data_q[15:8] <= merge8(dl_data_q[15:8], wb0, be0);
      else if (reg_addr == gpio_pkg::OFF_DL_DIR && be_half)
        dl_dir_q <= {wb1, wb0};
      else if (reg_addr == gpio_pkg::OFF_DL_DIR_LO)
        dl_dir_q[7:0] <= merge8(dl_dir_q[7:0], wb0, be0);
      else if (reg_addr == gpio_pkg::OFF_DL_DIR_HI)
        dl_dir_q[15:8] <= merge8(dl_dir_q[15:8], wb0, be0);
      else if (reg_addr == gpio_pkg::OFF_DL_FSEL && be_half)
        dl_fsel_q <= {wb1, wb0};
    end
  end
  // ****************************************
  // Pin drive and control-mode override
  // ****************************************
  logic [5:0]  cm_mode;
  logic [7:0]  cs_mode;
  logic [7:0]  ct_mode;
  logic [15:0] cm_ctrl_v;
  logic [15:0] cs_ctrl_v;
  logic [15:0] ct_ctrl_v;
  logic [15:0] cm_out_d;
  logic [15:0] cm_oe_d;
  logic [15:0] cs_out_d;
  logic [15:0] cs_oe_d;
  logic [15:0] ct_out_d;
  logic [15:0] ct_oe_d;
  logic [15:0] dl_out_d;
  logic [15:0] dl_oe_d;
  // Pins without a control function ignore their select bit
  assign cm_mode = cm_fsel_q[5:0] & gpio_pkg::CM_CTRL_MASK;
  assign cs_mode = cs_fsel_q & gpio_pkg::CS_CTRL_MASK;
  assign ct_mode = ct_fsel_q & gpio_pkg::CT_CTRL_MASK;
  assign cm_ctrl_v = {12'h000, 1'b0, bus_ctrl_out.hold_acknowledge,
                      bus_ctrl_out.clock_output, 1'b0};
  assign cs_ctrl_v = {12'h000, bus_ctrl_out.chip_select};
  assign ct_ctrl_v = {8'h00, 1'b0, bus_ctrl_out.address_strobe, 1'b0,
                      bus_ctrl_out.read_strobe, 2'b00,
                      bus_ctrl_out.write_strobe_1,
                      bus_ctrl_out.write_strobe_0};
  assign cm_out_d = pick({10'h000, cm_mode}, cm_ctrl_v, {10'h000, cm_data_q[5:0]});
  assign cm_oe_d  = pick({10'h000, cm_mode}, {10'h000, gpio_pkg::CM_CTRL_OE_N},
                         {10'h000, cm_dir_q[5:0]});
  assign cs_out_d = pick({8'h00, cs_mode}, cs_ctrl_v, {8'h00, cs_data_q});
  assign cs_oe_d  = pick({8'h00, cs_mode}, {8'h00, gpio_pkg::CS_CTRL_OE_N},
                         {8'h00, cs_dir_q});
  assign ct_out_d = pick({8'h00, ct_mode}, ct_ctrl_v, {8'h00, ct_data_q});
  assign ct_oe_d  = pick({8'h00, ct_mode}, {8'h00, gpio_pkg::CT_CTRL_OE_N},
                         {8'h00, ct_dir_q});
  assign dl_out_d = pick(dl_fsel_q, bus_ctrl_out.ad_out, dl_data_q);
  assign dl_oe_d  = pick(dl_fsel_q, {16{~bus_ctrl_out.ad_drive}}, dl_dir_q);
  // One register stage on every pad output keeps them glitch free
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {cd_pad_out, cm_pad_out, cs_pad_out, ct_pad_out, dl_pad_out}      <= '0;
      {cd_pad_oe_n, cm_pad_oe_n, cs_pad_oe_n, ct_pad_oe_n, dl_pad_oe_n} <= '1;
    end
    else
    begin
      cd_pad_out  <= cd_data_q[3:0];
      cd_pad_oe_n <= cd_dir_q[3:0];
      cm_pad_out  <= cm_out_d[5:0];
      cm_pad_oe_n <= cm_oe_d[5:0];
      cs_pad_out  <= cs_out_d[7:0];
      cs_pad_oe_n <= cs_oe_d[7:0];
      ct_pad_out  <= ct_out_d[7:0];
      ct_pad_oe_n <= ct_oe_d[7:0];
      dl_pad_out  <= dl_out_d;
      dl_pad_oe_n <= dl_oe_d;
    end
  end
  // ****************************************
  // Pin inputs toward the bus controller
  // ****************************************
  // Wait and hold request read as inactive unless the pin is handed to the controller; ad_in always follows the DL pins
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      bus_ctrl_in <= '0;
    else
    begin
      bus_ctrl_in.ad_in            <= dl_pin;
      bus_ctrl_in.bus_wait         <= cm_pin[0] & cm_mode[0];
      bus_ctrl_in.bus_hold_request <= cm_pin[3] & cm_mode[3];
    end
  end
endmodule : bus_side_gpio_ports

// ===== bus_side_gpio_ports_assertions.sv
`timescale 1ns/1ps
module bus_side_gpio_ports_assertions (
  input logic                      ref_clk,
  input logic                      reset_n,
  input logic [7:0]                avs_address,
  input logic                      avs_read,
  input logic                      avs_write,
  input logic [31:0]               avs_readdata,
  input logic                      avs_waitrequest,
  input logic [5:0]                cm_pad_in,
  input logic [15:0]               dl_pad_in,
  input logic [3:0]                cd_pad_oe_n,
  input logic [5:0]                cm_pad_oe_n,
  input logic [15:0]               dl_pad_oe_n,
  input gpio_pkg::bus_ctrl_in_type bus_ctrl_in
);
  // ********
  // Settle count; pad to bus_ctrl_in is three flops deep
  // ********
  logic [2:0] up_q;
  wire        req = avs_read || avs_write;
  wire        rd_ans = avs_read && !avs_waitrequest;
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
      up_q <= 3'h0;
    else if (up_q != 3'h7)
      up_q <= up_q + 3'h1;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  take_answer_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered next cycle");
  answer_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer longer than one cycle");
  answer_cause_a: assert property (!avs_waitrequest |-> req && $past(req))
    else $error("answer without request");
  cd_read_a: assert property (rd_ans && avs_address == 8'h00 |-> ~|avs_readdata[31:4])
    else $error("port cd read has bits above its pins");
  cm_read_a: assert property (rd_ans && avs_address == 8'h08 |-> ~|avs_readdata[31:6])
    else $error("port cm read has bits above its pins");
  reset_in_a: assert property ($rose(reset_n) |-> ##2 &{cd_pad_oe_n, cm_pad_oe_n, dl_pad_oe_n})
    else $error("pads not inputs after reset");
  ad_follow_a: assert property (up_q == 3'h7 |-> bus_ctrl_in.ad_in == $past(dl_pad_in, 3))
    else $error("address data input not from wide port pads");
  wait_gate_a: assert property (up_q == 3'h7 && bus_ctrl_in.bus_wait |-> $past(cm_pad_in[0], 3))
    else $error("bus wait without pad level");
  hold_gate_a: assert property (up_q == 3'h7 && bus_ctrl_in.bus_hold_request |-> $past(cm_pad_in[3], 3))
    else $error("hold request without pad level");
  write_seen_c: cover property (avs_write && !avs_waitrequest);
  read_seen_c: cover property (rd_ans);
  wait_seen_c: cover property (bus_ctrl_in.bus_wait);
endmodule : bus_side_gpio_ports_assertions
bind bus_side_gpio_ports bus_side_gpio_ports_assertions chk_u (.ref_clk, .reset_n, .avs_address,
  .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .cm_pad_in, .dl_pad_in,
  .cd_pad_oe_n, .cm_pad_oe_n, .dl_pad_oe_n, .bus_ctrl_in);

// ===== bus_side_gpio_ports_bench.sv
`timescale 1ns/1ps
module bus_side_gpio_ports_bench;
  // ********
  // Stimulus and model state
  // ********
  logic                       ref_clk, reset_n, avs_read, avs_write, avs_waitrequest;
  logic [7:0]                 avs_address;
  logic [3:0]                 avs_byteenable;
  logic [31:0]                avs_writedata, avs_readdata;
  logic [41:0]                pin_in, pin_out, pin_oen, ext;
  gpio_pkg::bus_ctrl_out_type ctl, ctl_pins;
  gpio_pkg::bus_ctrl_in_type  ctl_back;
  int                         m[3][5], lv[5], miscompares, checks;
  int                         seed = 74662;
  int                         base[5] = '{0, 4, 10, 18, 26};
  int                         wdt[5] = '{4, 6, 8, 8, 16};
  bus_side_gpio_ports dut_u (.ref_clk, .reset_n, .avs_address, .avs_read, .avs_write,
    .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .cd_pad_in(pin_in[3:0]), .cd_pad_out(pin_out[3:0]), .cd_pad_oe_n(pin_oen[3:0]),
    .cm_pad_in(pin_in[9:4]), .cm_pad_out(pin_out[9:4]), .cm_pad_oe_n(pin_oen[9:4]),
    .cs_pad_in(pin_in[17:10]), .cs_pad_out(pin_out[17:10]), .cs_pad_oe_n(pin_oen[17:10]),
    .ct_pad_in(pin_in[25:18]), .ct_pad_out(pin_out[25:18]), .ct_pad_oe_n(pin_oen[25:18]),
    .dl_pad_in(pin_in[41:26]), .dl_pad_out(pin_out[41:26]), .dl_pad_oe_n(pin_oen[41:26]),
    .bus_ctrl_out(ctl_pins), .bus_ctrl_in(ctl_back));
  pad_partner far_u (.ref_clk, .drive_level(ext), .pad_out(pin_out), .pad_oe_n(pin_oen),
    .ctrl_cmd(ctl), .pad_in(pin_in), .bus_ctrl_out(ctl_pins));
  initial
  begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic finish_test();
    if (miscompares == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] b,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge ref_clk);
    {avs_write, avs_read, avs_address, avs_byteenable, avs_writedata} <= {w, !w, a, b, d};
    @(posedge ref_clk);
    for (n = 0; n < 40 && avs_waitrequest !== 1'h0; n++)
      @(posedge ref_clk);
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    check(n < 40, 1, "bus timeout");
    if (n == 40)
      finish_test();
  endtask : bus
  // Kind 0 data, 1 direction, 2 select; view 1 low byte, 2 high byte
  function automatic bit decode(input logic [7:0] a, output int k, output int p, output int v);
    int i;
    i = a / 4;
    v = 0;
    p = i < 2 ? 0 : i < 11 ? (i - 2) / 3 + 1 : 4;
    k = i < 2 ? i : i < 11 ? (i - 2) % 3 : (i - 11) / 3;
    v = i < 11 ? 0 : (i - 11) % 3;
    return i < 18;
  endfunction : decode
  function automatic void model_write(input logic [7:0] a, input logic [3:0] b,
                                      input logic [31:0] d);
    int k, p, v;
    if (!decode(a, k, p, v))
      return;
    if (p < 4 && b[0])
      m[k][p] = d[7:0];
    else if (p == 4 && v == 0 && b[1:0] == 2'h3)
      m[k][4] = d[15:0];
    else if (p == 4 && v != 0 && b[0])
      m[k][4] = v == 1 ? m[k][4] & 16'hFF00 | d[7:0] : m[k][4] & 16'h00FF | d[7:0] << 8;
  endfunction : model_write
  function automatic void exp_pins(input int p, output int o, output int n);
    int cv[5], dm[5], s;
    cv = '{0, {ctl.hold_acknowledge, ctl.clock_output, 1'h0}, ctl.chip_select,
           {ctl.address_strobe, 1'h0, ctl.read_strobe, 2'h0, ctl.write_strobe_1,
            ctl.write_strobe_0}, ctl.ad_out};
    dm = '{0, 6'h06, 8'h0F, 8'h53, 16'hFFFF};
    s = m[2][p] & dm[p];
    o = (m[0][p] & ~s | cv[p] & s) & (1 << wdt[p]) - 1;
    n = (m[1][p] & ~s | (p == 4 && !ctl.ad_drive ? s : 0)) & (1 << wdt[p]) - 1;
    if (p == 1)
      n = n | m[2][1] & 9;
  endfunction : exp_pins
  function automatic int exp_rd(input logic [7:0] a);
    int k, p, v, r;
    if (!decode(a, k, p, v))
      return 0;
    r = k == 0 ? lv[p] : m[k][p];
    return v == 1 ? r & 8'hFF : v == 2 ? r >> 8 & 8'hFF : r;
  endfunction : exp_rd
  task automatic check_all();
    int o, n;
    logic [31:0] q;
    repeat (6) @(posedge ref_clk);
    for (int p = 0; p < 5; p++)
    begin
      exp_pins(p, o, n);
      lv[p] = (n & int'(ext >> base[p]) | ~n & o) & (1 << wdt[p]) - 1;
      check(pin_oen >> base[p] & (1 << wdt[p]) - 1, n, "direction");
      check(pin_out >> base[p] & ~n & (1 << wdt[p]) - 1, o & ~n, "drive");
    end
    check(ctl_back, {lv[4][15:0], lv[1][0] & m[2][1][0], lv[1][3] & m[2][1][3]}, "ctrl");
    for (int i = 0; i < 19; i++)
    begin
      bus(1'h0, 8'(4 * i), 4'hF, 32'h0, q);
      check(q, exp_rd(8'(4 * i)), "readback");
    end
  endtask : check_all
  initial
  begin
    logic [7:0] a;
    logic [3:0] b;
    logic [31:0] d, q;
    reset_n = 1'h0;
    {avs_read, avs_write, avs_address, avs_byteenable, avs_writedata} = '0;
    ext = '0;
    ctl = '0;
    foreach (m[k, p])
      m[k][p] = k == 1 ? (p == 4 ? 16'hFFFF : 8'hFF) : 0;
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'h1;
    repeat (3) @(posedge ref_clk);
    check_all();
    repeat (150)
    begin
      a = 8'(4 * (($random(seed) & 31) % 19));
      b = $random(seed);
      d = $random(seed);
      bus(1'h1, a, b, d, q);
      model_write(a, b, d);
      ext <= {$random(seed), $random(seed)};
      ctl <= $random(seed);
      check_all();
    end
    finish_test();
  end
endmodule : bus_side_gpio_ports_bench

// ===== gpio_pkg.sv
package gpio_pkg;

  // ****************************************
  // Bus geometry
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int BE_W   = 4;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFF_CD_DATA      = 8'h00;
  localparam logic [7:0] OFF_CD_DIR       = 8'h04;
  localparam logic [7:0] OFF_CM_DATA      = 8'h08;
  localparam logic [7:0] OFF_CM_DIR       = 8'h0C;
  localparam logic [7:0] OFF_CM_FSEL      = 8'h10;
  localparam logic [7:0] OFF_CS_DATA      = 8'h14;
  localparam logic [7:0] OFF_CS_DIR       = 8'h18;
  localparam logic [7:0] OFF_CS_FSEL      = 8'h1C;
  localparam logic [7:0] OFF_CT_DATA      = 8'h20;
  localparam logic [7:0] OFF_CT_DIR       = 8'h24;
  localparam logic [7:0] OFF_CT_FSEL      = 8'h28;
  localparam logic [7:0] OFF_DL_DATA      = 8'h2C;
  localparam logic [7:0] OFF_DL_DATA_LO   = 8'h30;
  localparam logic [7:0] OFF_DL_DATA_HI   = 8'h34;
  localparam logic [7:0] OFF_DL_DIR       = 8'h38;
  localparam logic [7:0] OFF_DL_DIR_LO    = 8'h3C;
  localparam logic [7:0] OFF_DL_DIR_HI    = 8'h40;
  localparam logic [7:0] OFF_DL_FSEL      = 8'h44;

  // ****************************************
  // Pin counts and reset values
  // ****************************************
  localparam int CD_PINS  = 4;
  localparam int CM_PINS  = 6;
  localparam int CS_PINS  = 8;
  localparam int CT_PINS  = 8;
  localparam int DL_PINS  = 16;
  localparam int ALL_PINS = CD_PINS + CM_PINS + CS_PINS + CT_PINS + DL_PINS;

  localparam logic [7:0]  DATA8_RESET  = 8'h00;
  localparam logic [7:0]  DIR8_RESET   = 8'hFF;
  localparam logic [7:0]  FSEL8_RESET  = 8'h00;
  localparam logic [15:0] DATA16_RESET = 16'h0000;
  localparam logic [15:0] DIR16_RESET  = 16'hFFFF;
  localparam logic [15:0] FSEL16_RESET = 16'h0000;

  // ****************************************
  // Pins that own a control function
  // ****************************************
  localparam logic [5:0] CM_CTRL_MASK = 6'h0F;
  localparam logic [5:0] CM_CTRL_OE_N = 6'h39;
  localparam logic [7:0] CS_CTRL_MASK = 8'h0F;
  localparam logic [7:0] CS_CTRL_OE_N = 8'hF0;
  localparam logic [7:0] CT_CTRL_MASK = 8'h53;
  localparam logic [7:0] CT_CTRL_OE_N = 8'hAC;

  // ****************************************
  // Bus controller carriers
  // ****************************************
  typedef struct packed {
    logic [15:0] ad_out;
    logic        ad_drive;
    logic        clock_output;
    logic        hold_acknowledge;
    logic [3:0]  chip_select;
    logic        write_strobe_0;
    logic        write_strobe_1;
    logic        read_strobe;
    logic        address_strobe;
  } bus_ctrl_out_type;

  typedef struct packed {
    logic [15:0] ad_in;
    logic        bus_wait;
    logic        bus_hold_request;
  } bus_ctrl_in_type;

  typedef enum logic [1:0] {
    SLV_IDLE = 2'b01,
    SLV_DONE = 2'b10
  } slave_state_type;

endpackage : gpio_pkg

// ===== pad_partner.sv
`timescale 1ns/1ps
// ********
// Board pads and external bus controller
// ********
module pad_partner (
  input  logic                       ref_clk,
  input  logic [41:0]                drive_level,
  input  logic [41:0]                pad_out,
  input  logic [41:0]                pad_oe_n,
  input  gpio_pkg::bus_ctrl_out_type ctrl_cmd,
  output logic [41:0]                pad_in,
  output gpio_pkg::bus_ctrl_out_type bus_ctrl_out
);
  // Released pads show the board level, never the last drive
  assign pad_in = pad_oe_n & drive_level | ~pad_oe_n & pad_out;
  always_ff @(posedge ref_clk)
    bus_ctrl_out <= ctrl_cmd;
endmodule : pad_partner
